// ===== design/ccm_regs.vh
// register map, field layout and constants of the clock monitor block
// Operation
// R1: ext pin select bits 3:0 pick oscillator 0000, main pll 0001, ext in one 0011, lpo low 0100, lpo high 0101.
// R2: ext pin codes 0110 second pll, 0111 ext in two, 1000 cpu, 1001 os timer, 1011/1101/1110 async clocks; others reserved.
// R3: timer pin select bits 11:8 give osc valid 0000, pll valid 0001, lpo high valid 0101, pll2 valid 0110, lpo low 1000.
// R4: an oscillator outside its valid window sets the fail flag in bit 0 of the global status register.
// R5: on oscillator failure every domain fed by the oscillator moves to the lpo high clock as limp clock.
// R6: the oscillator counts as valid only when above a quarter and below four times the lpo high frequency.
// R7: the ext clock pin can carry a prescaled copy of the selected internal clock.
// R8: each comparator has a reference down-counter and a test down-counter, loaded from seeds and started together.
// R9: the reference counter opens a fixed-width counting window once it has counted its pulses.
// R10: the test counter gives a pulse exactly one cycle wide when it has counted its pulses.
// R11: the comparator flags an error when the test counter does not reach zero inside the window.
// R12: a comparator error reaches the cpu as an interrupt request.
// R13: comparator one reference source is lpo high on 0x5, jtag clock on 0xa, else the oscillator.
// R14: comparator one test source is timer pin 31 unless key is 0xa, then codes 0x0..0xf per the source map.
// R15: comparator two reference source is the jtag clock on 0xa, else the oscillator.
// R16: comparator two test source is second timer pin 0 unless key is 0xa; then 0x0..0x7 reserved, 0x8..0xf periph.
// R17: the fail flag and comparator errors stay set until software clears them.
`ifndef CCM_REGS_VH
`define CCM_REGS_VH

`define CCM_ADDR_W 8
`define CCM_OFF_TEST_SEL 8'h00
`define CCM_OFF_STATUS 8'h04
`define CCM_OFF_MASK 8'h08
`define CCM_OFF_STATE 8'h0c
`define CCM_OFF_DCC_BASE 8'h10
`define CCM_DCC_STRIDE 8'h10
`define CCM_DCC_CTRL 2'h0
`define CCM_DCC_SEED0 2'h1
`define CCM_DCC_SEED1 2'h2
`define CCM_DCC_WIN 2'h3

`define CCM_TEST_SEL_RST 32'h0000_0000
`define CCM_TEST_SEL_MASK 32'h00ff_0f0f
`define CCM_ECP_LSB 0
`define CCM_GIO_LSB 8
`define CCM_PRESC_LSB 16

`define CCM_ST_FLAG_A 0
`define CCM_ST_DCC_ERR 1
`define CCM_ST_DCC_DONE 3
`define CCM_ST_W 5

`define CCM_CTRL_SRC0_LSB 0
`define CCM_CTRL_SRC1_LSB 4
`define CCM_CTRL_KEY_LSB 8
`define CCM_CTRL_START 16
`define CCM_CTRL_MASK 32'h0000_0fff
`define CCM_KEY_EN 4'ha
`define CCM_SRC_LPOH 4'h5
`define CCM_SRC_TCK 4'ha

`define CCM_SEED_W 20
`define CCM_SEED_RST 20'h00000

`define CCM_MON_WIN 8'h10
`define CCM_MON_LO 8'h04
`define CCM_MON_HI 8'h40

`define CCM_NSRC 22
`endif

// ===== design/ccm_dcc.v
// one dual clock comparator working on synchronised edge pulses
`timescale 1ns/10ps
`include "ccm_regs.vh"
module ccm_dcc (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire ref_edge,
    input wire test_edge,
    input wire [`CCM_SEED_W-1:0] seed_ref,
    input wire [`CCM_SEED_W-1:0] seed_test,
    input wire [`CCM_SEED_W-1:0] seed_window,
    output reg busy_reg,
    output reg error_reg,
    output reg done_reg,
    output reg test_zero_reg
);
    localparam S_IDLE = 2'd0;
    localparam S_COUNT = 2'd1;
    localparam S_WINDOW = 2'd2;

    reg [1:0] state_reg;
    reg [`CCM_SEED_W-1:0] cnt0_reg;
    reg [`CCM_SEED_W-1:0] cnt1_reg;
    reg [`CCM_SEED_W-1:0] win_reg;
    wire test_hit;
    wire ref_last;
    wire win_last;

    assign test_hit = test_edge && (cnt1_reg == 1);
    assign ref_last = ref_edge && (cnt0_reg <= 1);
    assign win_last = ref_edge && (win_reg <= 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            cnt0_reg <= `CCM_SEED_RST;
            cnt1_reg <= `CCM_SEED_RST;
            win_reg <= `CCM_SEED_RST;
            busy_reg <= 1'b0;
            error_reg <= 1'b0;
            done_reg <= 1'b0;
            test_zero_reg <= 1'b0;
        end else begin
            error_reg <= 1'b0;
            done_reg <= 1'b0;
            test_zero_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        // both counters load and run from the same edge
                        cnt0_reg <= seed_ref; // R8
                        cnt1_reg <= seed_test; // R8
                        win_reg <= seed_window;
                        busy_reg <= 1'b1;
                        state_reg <= S_COUNT;
                    end
                end
                S_COUNT: begin
                    if (ref_edge && cnt0_reg != 0)
                        cnt0_reg <= cnt0_reg - 1'b1;
                    if (test_edge && cnt1_reg != 0)
                        cnt1_reg <= cnt1_reg - 1'b1;
                    if (test_hit) begin
                        // test clock too fast: zero before window
                        test_zero_reg <= 1'b1; // R10
                        error_reg <= 1'b1; // R11
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end else if (ref_last) begin
                        state_reg <= S_WINDOW; // R9
                    end
                end
                S_WINDOW: begin
                    if (ref_edge && win_reg != 0)
                        win_reg <= win_reg - 1'b1; // R9
                    if (test_edge && cnt1_reg != 0)
                        cnt1_reg <= cnt1_reg - 1'b1;
                    if (test_hit) begin
                        test_zero_reg <= 1'b1; // R10
                        done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end else if (win_last) begin
                        error_reg <= 1'b1; // R11
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    busy_reg <= 1'b0;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== design/ccm_top.v
// clock test multiplexer, oscillator monitor and two clock comparators
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "ccm_regs.vh"
module ccm_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`CCM_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire main_osc_input,
    input wire main_pll_clock,
    input wire ext_clock_in_one,
    input wire lpo_low_clock,
    input wire lpo_high_clock,
    input wire second_pll_clock,
    input wire ext_clock_in_two,
    input wire cpu_clock,
    input wire os_timer_base_clock,
    input wire periph_async_clock_one,
    input wire periph_async_clock_three,
    input wire periph_async_clock_four,
    input wire jtag_test_clock,
    input wire timer_pin_thirtyone,
    input wire second_timer_pin_zero,
    input wire flash_pump_clock,
    input wire ring_osc_clock,
    input wire peripheral_clock,
    input wire osc_valid,
    input wire main_pll_valid,
    input wire lpo_high_valid,
    input wire second_pll_valid,
    output reg ext_clock_out_pin,
    output reg timer_pin_twelve,
    output reg limp_mode,
    output reg irq
);
    localparam I_OSC = 0;
    localparam I_PLL1 = 1;
    localparam I_EXT1 = 2;
    localparam I_LPOL = 3;
    localparam I_LPOH = 4;
    localparam I_PLL2 = 5;
    localparam I_EXT2 = 6;
    localparam I_CPU = 7;
    localparam I_RTI = 8;
    localparam I_PA1 = 9;
    localparam I_PA3 = 10;
    localparam I_PA4 = 11;
    localparam I_TCK = 12;
    localparam I_HET31 = 13;
    localparam I_HET2 = 14;
    localparam I_PUMP = 15;
    localparam I_RING = 16;
    localparam I_PERI = 17;
    localparam I_OSCV = 18;
    localparam I_PLL1V = 19;
    localparam I_LPOHV = 20;
    localparam I_PLL2V = 21;

    wire [`CCM_NSRC-1:0] raw;
    reg [`CCM_NSRC-1:0] sync1_reg;
    reg [`CCM_NSRC-1:0] sync2_reg;
    reg [`CCM_NSRC-1:0] last_reg;
    wire [`CCM_NSRC-1:0] rise;

    assign raw = {second_pll_valid, lpo_high_valid, main_pll_valid,
        osc_valid, peripheral_clock, ring_osc_clock, flash_pump_clock,
        second_timer_pin_zero, timer_pin_thirtyone, jtag_test_clock,
        periph_async_clock_four, periph_async_clock_three,
        periph_async_clock_one, os_timer_base_clock, cpu_clock,
        ext_clock_in_two, second_pll_clock, lpo_high_clock, lpo_low_clock,
        ext_clock_in_one, main_pll_clock, main_osc_input};

    // two-stage synchroniser and rising edge detect per source
    genvar gi;
    generate
        for (gi = 0; gi < `CCM_NSRC; gi = gi + 1) begin : g_sync
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    last_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    last_reg[gi] <= sync2_reg[gi];
                end
            end
            assign rise[gi] = sync2_reg[gi] & ~last_reg[gi];
        end
    endgenerate

    reg [31:0] test_sel_reg;
    reg [`CCM_ST_W-1:0] status_reg;
    reg [`CCM_ST_W-1:0] status_next;
    reg [`CCM_ST_W-1:0] mask_reg;
    reg [11:0] dcc_ctrl_reg [0:1];
    reg [`CCM_SEED_W-1:0] seed0_reg [0:1];
    reg [`CCM_SEED_W-1:0] seed1_reg [0:1];
    reg [`CCM_SEED_W-1:0] win_reg [0:1];
    reg [1:0] start_reg;

    wire [3:0] ecp_sel;
    wire [3:0] gio_sel;
    wire [7:0] presc;
    assign ecp_sel = test_sel_reg[`CCM_ECP_LSB+3:`CCM_ECP_LSB];
    assign gio_sel = test_sel_reg[`CCM_GIO_LSB+3:`CCM_GIO_LSB];
    assign presc = test_sel_reg[`CCM_PRESC_LSB+7:`CCM_PRESC_LSB];

    // ext pin source mux on synchronised levels and edges
    reg ecp_lvl;
    reg ecp_rise;
    integer ecp_idx;
    reg ecp_ok;
    always @* begin
        ecp_idx = I_OSC;
        ecp_ok = 1'b1;
        case (ecp_sel)
            4'h0: ecp_idx = I_OSC; // R1
            4'h1: ecp_idx = I_PLL1; // R1
            4'h3: ecp_idx = I_EXT1; // R1
            4'h4: ecp_idx = I_LPOL; // R1
            4'h5: ecp_idx = I_LPOH; // R1
            4'h6: ecp_idx = I_PLL2; // R2
            4'h7: ecp_idx = I_EXT2; // R2
            4'h8: ecp_idx = I_CPU; // R2
            4'h9: ecp_idx = I_RTI; // R2
            4'hb: ecp_idx = I_PA1; // R2
            4'hd: ecp_idx = I_PA3; // R2
            4'he: ecp_idx = I_PA4; // R2
            default: ecp_ok = 1'b0; // R2
        endcase
        ecp_lvl = ecp_ok & sync2_reg[ecp_idx];
        ecp_rise = ecp_ok & rise[ecp_idx];
    end

    // prescaler: zero passes the level, n toggles every n rising edges
    reg [7:0] presc_cnt_reg;
    reg presc_out_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt_reg <= 8'h00;
            presc_out_reg <= 1'b0;
        end else if (ecp_rise) begin
            if (presc_cnt_reg + 8'h01 >= presc) begin
                presc_cnt_reg <= 8'h00;
                presc_out_reg <= ~presc_out_reg; // R7
            end else begin
                presc_cnt_reg <= presc_cnt_reg + 8'h01;
            end
        end
    end

    reg gio_lvl;
    always @* begin
        case (gio_sel)
            4'h0: gio_lvl = sync2_reg[I_OSCV]; // R3
            4'h1: gio_lvl = sync2_reg[I_PLL1V]; // R3
            4'h5: gio_lvl = sync2_reg[I_LPOHV]; // R3
            4'h6: gio_lvl = sync2_reg[I_PLL2V]; // R3
            4'h8: gio_lvl = sync2_reg[I_LPOL]; // R3
            default: gio_lvl = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_clock_out_pin <= 1'b0;
            timer_pin_twelve <= 1'b0;
        end else begin
            ext_clock_out_pin <= (presc == 8'h00) ? ecp_lvl : presc_out_reg;
            timer_pin_twelve <= gio_lvl;
        end
    end

    // oscillator monitor: osc edges counted over a window of lpo edges
    reg [7:0] mon_win_reg;
    reg [7:0] mon_cnt_reg;
    reg flag_a_pulse;
    reg osc_ok_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_win_reg <= 8'h00;
            mon_cnt_reg <= 8'h00;
            flag_a_pulse <= 1'b0;
            osc_ok_reg <= 1'b0;
        end else begin
            flag_a_pulse <= 1'b0;
            if (rise[I_LPOH] && mon_win_reg == `CCM_MON_WIN - 8'h01) begin
                mon_win_reg <= 8'h00;
                mon_cnt_reg <= {7'h00, rise[I_OSC]};
                // strict bounds at a quarter and four times lpo rate
                if (mon_cnt_reg > `CCM_MON_LO && mon_cnt_reg < `CCM_MON_HI)
                    osc_ok_reg <= 1'b1; // R6
                else begin
                    osc_ok_reg <= 1'b0; // R6
                    flag_a_pulse <= 1'b1; // R4
                end
            end else begin
                if (rise[I_LPOH])
                    mon_win_reg <= mon_win_reg + 8'h01;
                if (rise[I_OSC] && mon_cnt_reg != 8'hff)
                    mon_cnt_reg <= mon_cnt_reg + 8'h01;
            end
        end
    end

    // comparator source selection
    wire [3:0] src0_a;
    wire [3:0] src1_a;
    wire [3:0] key_a;
    wire [3:0] src0_b;
    wire [3:0] src1_b;
    wire [3:0] key_b;
    assign src0_a = dcc_ctrl_reg[0][`CCM_CTRL_SRC0_LSB+3:`CCM_CTRL_SRC0_LSB];
    assign src1_a = dcc_ctrl_reg[0][`CCM_CTRL_SRC1_LSB+3:`CCM_CTRL_SRC1_LSB];
    assign key_a = dcc_ctrl_reg[0][`CCM_CTRL_KEY_LSB+3:`CCM_CTRL_KEY_LSB];
    assign src0_b = dcc_ctrl_reg[1][`CCM_CTRL_SRC0_LSB+3:`CCM_CTRL_SRC0_LSB];
    assign src1_b = dcc_ctrl_reg[1][`CCM_CTRL_SRC1_LSB+3:`CCM_CTRL_SRC1_LSB];
    assign key_b = dcc_ctrl_reg[1][`CCM_CTRL_KEY_LSB+3:`CCM_CTRL_KEY_LSB];

    reg [1:0] ref_edge;
    reg [1:0] test_edge;
    always @* begin
        if (src0_a == `CCM_SRC_LPOH)
            ref_edge[0] = rise[I_LPOH]; // R13
        else if (src0_a == `CCM_SRC_TCK)
            ref_edge[0] = rise[I_TCK]; // R13
        else
            ref_edge[0] = rise[I_OSC]; // R13
        if (src0_b == `CCM_SRC_TCK)
            ref_edge[1] = rise[I_TCK]; // R15
        else
            ref_edge[1] = rise[I_OSC]; // R15
        if (key_a != `CCM_KEY_EN)
            test_edge[0] = rise[I_HET31]; // R14
        else begin
            case (src1_a)
                4'h0: test_edge[0] = rise[I_PLL1]; // R14
                4'h2: test_edge[0] = rise[I_LPOL]; // R14
                4'h3: test_edge[0] = rise[I_LPOH]; // R14
                4'h4: test_edge[0] = rise[I_PUMP]; // R14
                4'h5: test_edge[0] = rise[I_EXT1]; // R14
                4'h6: test_edge[0] = rise[I_EXT2]; // R14
                4'h7: test_edge[0] = rise[I_RING]; // R14
                4'h1: test_edge[0] = 1'b0;
                default: test_edge[0] = rise[I_PERI]; // R14
            endcase
        end
        if (key_b != `CCM_KEY_EN)
            test_edge[1] = rise[I_HET2]; // R16
        else if (src1_b[3])
            test_edge[1] = rise[I_PERI]; // R16
        else
            test_edge[1] = 1'b0; // R16
    end

    wire [1:0] dcc_busy;
    wire [1:0] dcc_err;
    wire [1:0] dcc_done;
    genvar gd;
    generate
        for (gd = 0; gd < 2; gd = gd + 1) begin : g_dcc
            ccm_dcc u_dcc (
                .pclk(pclk),
                .presetn(presetn),
                .start(start_reg[gd]),
                .ref_edge(ref_edge[gd]),
                .test_edge(test_edge[gd]),
                .seed_ref(seed0_reg[gd]),
                .seed_test(seed1_reg[gd]),
                .seed_window(win_reg[gd]),
                .busy_reg(dcc_busy[gd]),
                .error_reg(dcc_err[gd]),
                .done_reg(dcc_done[gd]),
                .test_zero_reg()
            );
        end
    endgenerate

    // apb decode
    wire acc;
    wire wr;
    wire in_dcc;
    wire dcc_sel;
    wire [1:0] dcc_slot;
    reg hit;
    reg [31:0] rd;
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign in_dcc = (paddr >= `CCM_OFF_DCC_BASE) &&
        (paddr < `CCM_OFF_DCC_BASE + 2 * `CCM_DCC_STRIDE);
    assign dcc_sel = paddr[5];
    assign dcc_slot = paddr[3:2];

    always @* begin
        hit = 1'b1;
        rd = 32'h0000_0000;
        if (paddr[1:0] != 2'b00)
            hit = 1'b0;
        else if (in_dcc) begin
            case (dcc_slot)
                `CCM_DCC_CTRL: rd = {15'h0000, dcc_busy[dcc_sel], 4'h0,
                    dcc_ctrl_reg[dcc_sel]};
                `CCM_DCC_SEED0: rd = {12'h000, seed0_reg[dcc_sel]};
                `CCM_DCC_SEED1: rd = {12'h000, seed1_reg[dcc_sel]};
                default: rd = {12'h000, win_reg[dcc_sel]};
            endcase
        end else begin
            case (paddr)
                `CCM_OFF_TEST_SEL: rd = test_sel_reg;
                `CCM_OFF_STATUS: rd = {27'h0000000, status_reg};
                `CCM_OFF_MASK: rd = {27'h0000000, mask_reg};
                `CCM_OFF_STATE: rd = {28'h0000000, dcc_busy, osc_ok_reg,
                    limp_mode};
                default: hit = 1'b0;
            endcase
        end
    end

    // sticky events; a new event wins over a write-one clear
    always @* begin
        status_next = status_reg;
        if (wr && paddr == `CCM_OFF_STATUS)
            status_next = status_reg & ~pwdata[`CCM_ST_W-1:0]; // R17
        status_next = status_next |
            {dcc_done, dcc_err, flag_a_pulse}; // R4 R11
    end

    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            test_sel_reg <= `CCM_TEST_SEL_RST;
            status_reg <= {`CCM_ST_W{1'b0}};
            mask_reg <= {`CCM_ST_W{1'b0}};
            start_reg <= 2'b00;
            limp_mode <= 1'b0;
            irq <= 1'b0;
            for (k = 0; k < 2; k = k + 1) begin
                dcc_ctrl_reg[k] <= 12'h000;
                seed0_reg[k] <= `CCM_SEED_RST;
                seed1_reg[k] <= `CCM_SEED_RST;
                win_reg[k] <= `CCM_SEED_RST;
            end
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel & ~penable & ~pwrite & hit) ? rd : 32'h0000_0000;
            status_reg <= status_next;
            // domains on the oscillator follow the fail flag to limp clock
            limp_mode <= status_next[`CCM_ST_FLAG_A]; // R5
            irq <= |(status_next & mask_reg); // R12
            start_reg <= 2'b00;
            if (wr && hit) begin
                if (in_dcc) begin
                    case (dcc_slot)
                        `CCM_DCC_CTRL: begin
                            dcc_ctrl_reg[dcc_sel] <= pwdata[11:0];
                            start_reg[dcc_sel] <= pwdata[`CCM_CTRL_START];
                        end
                        `CCM_DCC_SEED0:
                            seed0_reg[dcc_sel] <= pwdata[`CCM_SEED_W-1:0];
                        `CCM_DCC_SEED1:
                            seed1_reg[dcc_sel] <= pwdata[`CCM_SEED_W-1:0];
                        default:
                            win_reg[dcc_sel] <= pwdata[`CCM_SEED_W-1:0];
                    endcase
                end else if (paddr == `CCM_OFF_TEST_SEL)
                    test_sel_reg <= pwdata & `CCM_TEST_SEL_MASK; // R1 R3
                else if (paddr == `CCM_OFF_MASK)
                    mask_reg <= pwdata[`CCM_ST_W-1:0];
            end
        end
    end
endmodule

// ===== testbench/ccm_top_properties.sv
// port-level assertions for the clock monitor block
`timescale 1ns/10ps
`include "ccm_regs.vh"
module ccm_top_properties (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`CCM_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire osc_valid,
    input wire ext_clock_out_pin,
    input wire timer_pin_twelve,
    input wire limp_mode,
    input wire irq
);
    reg [31:0] sel_q;
    reg [4:0] mask_q;
    wire acc_w = psel && penable && pready && pwrite;
    wire clr_w = acc_w && paddr == 8'h04 && pwdata[0];
    wire [3:0] ec = sel_q[3:0];
    wire [3:0] gc = sel_q[11:8];
    wire ecp_rsv = (ec == 4'h2 || ec == 4'ha || ec == 4'hc || ec == 4'hf)
        && sel_q[23:16] == 8'h00;
    wire gio_rsv = !(gc == 4'h0 || gc == 4'h1 || gc == 4'h5
        || gc == 4'h6 || gc == 4'h8);
    // shadow of the written select and mask values
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 32'h00000000;
            mask_q <= 5'h00;
        end else begin
            if (acc_w && paddr == 8'h00)
                sel_q <= pwdata & 32'h00ff0f0f;
            if (acc_w && paddr == 8'h08)
                mask_q <= pwdata[4:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_ecp_reserved_low: assert property (
        $stable(sel_q)[*8] ##0 ecp_rsv |-> !ext_clock_out_pin)
        else $error("ext pin active on reserved code");
    a_gio_reserved_low: assert property (
        $stable(sel_q)[*8] ##0 gio_rsv |-> !timer_pin_twelve)
        else $error("timer pin active on reserved code");
    a_gio_osc_valid: assert property (
        ($stable(sel_q) && $stable(osc_valid))[*8] ##0 gc == 4'h0
        |-> timer_pin_twelve == osc_valid)
        else $error("timer pin not showing osc valid");
    a_irq_masked_off: assert property (
        (mask_q == 5'h00)[*3] |-> !irq)
        else $error("irq with all bits masked");
    a_limp_held_set: assert property (
        $fell(limp_mode) |-> $past(clr_w) || $past(clr_w, 2))
        else $error("limp cleared without software clear");
endmodule
bind ccm_top ccm_top_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_valid(osc_valid), .ext_clock_out_pin(ext_clock_out_pin),
    .timer_pin_twelve(timer_pin_twelve), .limp_mode(limp_mode), .irq(irq));

// ===== testbench/tb_top.sv
// self-checking testbench for the clock monitor block
`timescale 1ns/10ps
module tb_top;
    localparam [15:0] EXP_E = 16'h6bfb;
    localparam [15:0] EXP_T = 16'h0163;
    reg pclk, presetn, psel, penable, pwrite, vld, eh, el, th;
    reg [7:0] paddr, cnt;
    reg [31:0] pwdata, rd;
    reg [1:0] osc_mode;
    integer miscompares, num_checks, i;
    wire [31:0] prdata;
    wire pready, pslverr, ext_pin, tpin, limp, irq;
    wire osc = osc_mode[1] ? cnt[1] : (osc_mode[0] & cnt[3]);
    ccm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_osc_input(osc), .main_pll_clock(cnt[2]),
        .ext_clock_in_one(cnt[3]), .lpo_low_clock(cnt[4]),
        .lpo_high_clock(cnt[3]), .second_pll_clock(cnt[2]),
        .ext_clock_in_two(cnt[4]), .cpu_clock(cnt[2]),
        .os_timer_base_clock(cnt[3]), .periph_async_clock_one(cnt[2]),
        .periph_async_clock_three(cnt[3]), .periph_async_clock_four(cnt[4]),
        .jtag_test_clock(cnt[2]), .timer_pin_thirtyone(cnt[2]),
        .second_timer_pin_zero(cnt[3]), .flash_pump_clock(cnt[2]),
        .ring_osc_clock(cnt[3]), .peripheral_clock(cnt[2]),
        .osc_valid(vld), .main_pll_valid(vld), .lpo_high_valid(vld),
        .second_pll_valid(vld), .ext_clock_out_pin(ext_pin),
        .timer_pin_twelve(tpin), .limp_mode(limp), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) cnt <= cnt + 8'h01;
    task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input ex);
        integer n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n = n + 1;
        end
        rd = prdata;
        chk("ready", {31'h0, pready}, 32'h1);
        chk("slverr", {31'h0, pslverr}, {31'h0, ex});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input [63:0] nm, input [7:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(nm, rd, e);
    endtask
    // seeds 4 and window 4 on the reference side, then poll busy
    task dcc(input [7:0] b, input [31:0] c, s1, ex, ei);
        integer n;
        n = 0;
        apb(1'b1, b + 8'h04, 32'h4, 1'b0);
        apb(1'b1, b + 8'h08, s1, 1'b0);
        apb(1'b1, b + 8'h0c, 32'h4, 1'b0);
        apb(1'b1, b, c, 1'b0);
        rd = 32'hc;
        while ((rd & 32'hc) != 32'h0 && n < 200) begin
            apb(1'b0, 8'h0c, 32'h0, 1'b0);
            n = n + 1;
        end
        rdc("dccstat", 8'h04, ex);
        chk("irq", {31'h0, irq}, ei);
        apb(1'b1, 8'h04, 32'h1f, 1'b0);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares = miscompares + 1;
        stop_test;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, cnt} = 0;
        osc_mode = 2'd1;
        vld = 1'b1;
        miscompares = 0;
        num_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc("sel", 8'h00, 32'h0);
        rdc("stat", 8'h04, 32'h0);
        rdc("mask", 8'h08, 32'h0);
        apb(1'b0, 8'hfc, 32'h0, 1'b1);
        apb(1'b1, 8'h00, 32'hffffffff, 1'b0);
        rdc("sel", 8'h00, 32'h00ff0f0f);
        for (i = 0; i < 16; i = i + 1) begin
            apb(1'b1, 8'h00, {20'h0, i[3:0], 4'h0, i[3:0]}, 1'b0);
            repeat (8) @(posedge pclk);
            {eh, el, th} = 3'b010;
            repeat (64) begin
                @(negedge pclk);
                eh = eh | ext_pin;
                el = el & ext_pin;
                th = th | tpin;
            end
            chk("extpin", {31'h0, eh & ~el}, {31'h0, EXP_E[i]});
            chk("tpin", {31'h0, th}, {31'h0, EXP_T[i]});
        end
        // prescale 2 on the main pll source: one toggle per 16 cycles
        apb(1'b1, 8'h00, 32'h00020001, 1'b0);
        repeat (8) @(negedge pclk);
        th = ext_pin;
        i = 0;
        repeat (64) begin
            @(negedge pclk);
            i = i + (ext_pin != th);
            th = ext_pin;
        end
        chk("presc", i, 32'd4);
        apb(1'b1, 8'h00, 32'h0, 1'b0);
        // stopped oscillator, then one at exactly four times the lpo rate
        for (i = 0; i < 2; i = i + 1) begin
            osc_mode <= (i == 0) ? 2'd0 : 2'd2;
            repeat (700) @(posedge pclk);
            rdc("stat", 8'h04, 32'h1);
            chk("limp", {31'h0, limp}, 32'h1);
            chk("irq", {31'h0, irq}, 32'h0);
            osc_mode <= 2'd1;
            repeat (600) @(posedge pclk);
            rdc("stat", 8'h04, 32'h1);
            apb(1'b1, 8'h08, 32'h1, 1'b0);
            repeat (2) @(posedge pclk);
            chk("irq", {31'h0, irq}, 32'h1);
            apb(1'b1, 8'h04, 32'h1, 1'b0);
            apb(1'b1, 8'h08, 32'h0, 1'b0);
            repeat (2) @(posedge pclk);
            chk("limp", {31'h0, limp}, 32'h0);
        end
        dcc(8'h10, 32'h00010a35, 32'd6, 32'h8, 32'h0);
        apb(1'b1, 8'h08, 32'h2, 1'b0);
        dcc(8'h10, 32'h00010a35, 32'd20, 32'h2, 32'h1);
        dcc(8'h20, 32'h00010a00, 32'd1, 32'h4, 32'h0);
        stop_test;
    end
endmodule
